// ==== mdbs_slave.v ====
// request decoder, local database and reply generator of the gateway slave port
`timescale 1ns/1ps
`default_nettype none
`include "mdbs_defines.vh"
module mdbs_slave #(
    parameter LOC_AW = 12,
    parameter RXB_AW = 6
) (
    input wire i_clk_sys,
    input wire i_reset,
    input wire [7:0] i_base_addr,
    input wire i_layout_packed,
    input wire i_scale_alt,
    input wire [15:0] i_station_status,
    input wire i_rx_valid,
    input wire [7:0] i_rx_byte,
    input wire i_rx_end,
    output reg o_busy,
    output reg o_tx_valid,
    output reg [7:0] o_tx_byte,
    output reg o_tx_last,
    input wire i_tx_ready,
    input wire i_db_wr,
    input wire [1:0] i_db_page,
    input wire [LOC_AW-1:0] i_db_loc,
    input wire [15:0] i_db_data,
    output reg o_cmd_valid,
    output reg [1:0] o_cmd_page,
    output reg [15:0] o_cmd_loc,
    output reg [15:0] o_cmd_data,
    input wire i_cmd_ready,
    output reg o_alarm_accept
);
    localparam RXB_DEPTH = 1 << RXB_AW;
    localparam DB_WORDS = 4 << LOC_AW;
    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_CHECK = 3'h1;
    localparam [2:0] S_WRITE = 3'h2;
    localparam [2:0] S_TX = 3'h3;

    reg [2:0] state_r;
    reg [7:0] rxb [0:RXB_DEPTH-1];
    reg [15:0] db_mem [0:DB_WORDS-1];
    reg [8:0] rx_cnt_r;
    reg rx_ovf_r;
    reg [15:0] rx_crc_r;
    reg [1:0] page_r;
    reg [7:0] exc_r;
    reg [8:0] len_r;
    reg [8:0] tx_idx_r;
    reg [15:0] tx_crc_r;
    reg [7:0] wr_cnt_r;
    reg cmd_pend_r;
    wire [15:0] rx_crc_nxt;
    wire [15:0] tx_crc_nxt;

    wire [7:0] f_addr = rxb[0];
    wire [7:0] f_fc = rxb[1];
    wire [15:0] f_loc = {rxb[2], rxb[3]};
    wire [15:0] f_qty = {rxb[4], rxb[5]};
    wire [7:0] f_bc = rxb[6];
    // the function code alone classifies the request
    wire fc_bits = (f_fc == `MDBS_FC_RD_COILS) || (f_fc == `MDBS_FC_RD_INPUTS);
    wire fc_regs = (f_fc == `MDBS_FC_RD_HOLD) || (f_fc == `MDBS_FC_RD_INREG);
    wire fc_wr1 = (f_fc == `MDBS_FC_WR_COIL) || (f_fc == `MDBS_FC_WR_REG);
    wire fc_coils = (f_fc == `MDBS_FC_WR_COILS);
    wire fc_wregs = (f_fc == `MDBS_FC_WR_REGS);
    wire fc_wr = fc_wr1 || fc_coils || fc_wregs;

    mdbs_crc16 u_rx_crc (
        .i_crc(rx_crc_r),
        .i_byte(i_rx_byte),
        .o_crc(rx_crc_nxt)
    );

    // reads come only from local storage, never from the field network
    function [15:0] rd_word(input [1:0] pg, input [15:0] l);
        begin
            if (pg == 2'h0 && l == `MDBS_LOC_STATUS) begin
                rd_word = i_station_status;
            end else if ((l >> LOC_AW) != 16'h0000) begin
                rd_word = 16'h0000;
            end else begin
                rd_word = db_mem[{pg, l[LOC_AW-1:0]}];
            end
        end
    endfunction

    function is_unit(input [1:0] pg, input [15:0] l);
        begin
            is_unit = (pg != 2'h0) || (l >= `MDBS_LOC_UNIT_STATUS);
        end
    endfunction

    // analogue commands are normalised to a 16-bit full range before forwarding
    function [15:0] scale(input [15:0] d);
        begin
            case ({i_layout_packed, i_scale_alt})
                2'b00: scale = {d[14:0], 1'b0};
                2'b01: scale = {d[11:0], 4'h0};
                2'b10: scale = d[15] ? 16'h0000 : {d[14:0], 1'b0};
                default: scale = d;
            endcase
        end
    endfunction

    // request checking
    reg chk_match;
    reg chk_bcast;
    reg [1:0] chk_page;
    reg [7:0] chk_off;
    reg [8:0] chk_exp;
    reg chk_qty_ok;
    reg [16:0] chk_last;
    reg chk_rng_ok;
    reg [7:0] chk_exc;
    reg [15:0] chk_nbytes;
    reg [8:0] chk_len;
    wire base_ok = (i_base_addr != `MDBS_ADDR_BCAST) && (i_base_addr <= `MDBS_ADDR_MAX);
    wire crc_ok = (rx_crc_r == 16'h0000) && (rx_cnt_r >= `MDBS_LEN_MIN);

    always @* begin
        chk_bcast = (f_addr == `MDBS_ADDR_BCAST);
        chk_off = f_addr - i_base_addr;
        chk_page = 2'h0;
        if (chk_bcast) begin
            chk_match = 1'b1;
        end else if (i_layout_packed) begin
            chk_match = base_ok && (f_addr == i_base_addr);
        end else begin
            chk_match = base_ok && (f_addr >= i_base_addr) && (f_addr <= `MDBS_ADDR_MAX)
                && (chk_off <= `MDBS_GEN_PAGES);
            chk_page = chk_off[1:0];
        end
        chk_exp = (fc_coils || fc_wregs) ? (`MDBS_LEN_MULTI + {1'b0, f_bc}) : `MDBS_LEN_FIXED;
        chk_nbytes = (f_qty + 16'h0007) >> 3;
        chk_qty_ok = 1'b1;
        chk_last = {1'b0, f_loc};
        if (fc_bits) begin
            chk_qty_ok = (f_qty != 16'h0000) && (f_qty <= `MDBS_MAX_BITS);
            chk_last = {1'b0, f_loc} + {1'b0, f_qty} - 17'h00001;
        end else if (fc_regs) begin
            chk_qty_ok = (f_qty != 16'h0000) && (f_qty <= `MDBS_MAX_REGS);
            chk_last = {1'b0, f_loc} + {1'b0, f_qty} - 17'h00001;
        end else if (fc_coils) begin
            chk_qty_ok = (f_qty != 16'h0000) && (f_qty <= `MDBS_MAX_WR_COILS)
                && ({8'h00, f_bc} == chk_nbytes);
        end else if (fc_wregs) begin
            chk_qty_ok = (f_qty != 16'h0000) && ({8'h00, f_bc} == {f_qty[14:0], 1'b0})
                && (!is_unit(chk_page, f_loc) || f_qty == 16'h0001);
            chk_last = {1'b0, f_loc} + {1'b0, f_qty} - 17'h00001;
        end
        if (fc_bits) begin
            chk_rng_ok = (chk_last >> (LOC_AW + 4)) == 17'h00000;
        end else begin
            chk_rng_ok = (chk_last >> LOC_AW) == 17'h00000;
        end
        if (!(fc_bits || fc_regs || fc_wr)) begin
            chk_exc = `MDBS_EXC_FUNC;
        end else if (rx_ovf_r || rx_cnt_r != chk_exp) begin
            chk_exc = `MDBS_EXC_FUNC;
        end else if (!chk_qty_ok) begin
            chk_exc = `MDBS_EXC_VALUE;
        end else if (!chk_rng_ok) begin
            chk_exc = `MDBS_EXC_ADDR;
        end else if (fc_wr && is_unit(chk_page, f_loc) && (cmd_pend_r || o_cmd_valid)) begin
            chk_exc = `MDBS_EXC_BUSY;
        end else begin
            chk_exc = `MDBS_EXC_NONE;
        end
        if (chk_exc != `MDBS_EXC_NONE) begin
            chk_len = 9'h003;
        end else if (fc_bits) begin
            chk_len = 9'h003 + chk_nbytes[8:0];
        end else if (fc_regs) begin
            chk_len = 9'h003 + {f_qty[7:0], 1'b0};
        end else begin
            chk_len = 9'h006;
        end
    end

    // write value for the current word of a write request
    reg [8:0] wr_pos;
    reg [15:0] wr_val;
    reg [15:0] wr_loc;
    reg [15:0] wr_mask;
    wire wr_last = fc_wregs ? (wr_cnt_r == f_qty[7:0] - 8'h01) : 1'b1;
    wire host_we = (state_r == S_WRITE) && !i_db_wr;

    always @* begin
        wr_pos = 9'h007 + {wr_cnt_r, 1'b0};
        wr_loc = f_loc + {8'h00, wr_cnt_r};
        wr_mask = ~(16'hffff << f_qty[4:0]);
        if (fc_wr1) begin
            wr_val = f_qty;
        end else if (fc_coils) begin
            wr_val = {rxb[8], rxb[7]} & wr_mask;
        end else begin
            wr_val = {rxb[wr_pos[RXB_AW-1:0]], rxb[wr_pos[RXB_AW-1:0] + 1'b1]};
        end
    end

    // reply byte for the current position
    reg [7:0] gen_byte;
    reg [15:0] gen_k;
    reg [15:0] gen_w;
    reg [15:0] gen_bit;
    reg [3:0] j;
    always @* begin
        gen_byte = 8'h00;
        gen_k = {7'h00, tx_idx_r} - 16'h0003;
        gen_w = 16'h0000;
        gen_bit = 16'h0000;
        if (tx_idx_r == len_r) begin
            gen_byte = tx_crc_r[7:0];
        end else if (tx_idx_r == len_r + 9'h001) begin
            gen_byte = tx_crc_r[15:8];
        end else if (tx_idx_r == 9'h000) begin
            gen_byte = f_addr;
        end else if (tx_idx_r == 9'h001) begin
            gen_byte = (exc_r != `MDBS_EXC_NONE) ? (f_fc | `MDBS_FC_EXC_FLAG) : f_fc;
        end else if (exc_r != `MDBS_EXC_NONE) begin
            gen_byte = exc_r;
        end else if (fc_wr) begin
            gen_byte = rxb[tx_idx_r[RXB_AW-1:0]];
        end else if (tx_idx_r == 9'h002) begin
            gen_byte = len_r[7:0] - 8'h03;
        end else if (fc_bits) begin
            for (j = 4'h0; j < 4'h8; j = j + 4'h1) begin
                gen_bit = {gen_k[12:0], j[2:0]};
                if (gen_bit < f_qty) begin
                    gen_w = rd_word(page_r, (f_loc + gen_bit) >> 4);
                    gen_byte[j[2:0]] = gen_w[(f_loc[3:0] + gen_bit[3:0])];
                end
            end
        end else begin
            gen_w = rd_word(page_r, f_loc + (gen_k >> 1));
            gen_byte = gen_k[0] ? gen_w[7:0] : gen_w[15:8];
        end
    end

    mdbs_crc16 u_tx_crc (
        .i_crc(tx_crc_r),
        .i_byte(gen_byte),
        .o_crc(tx_crc_nxt)
    );

    // storage has no reset; the field side wins a same-cycle collision and the host waits
    always @(posedge i_clk_sys) begin
        if (state_r == S_IDLE && i_rx_valid && rx_cnt_r < RXB_DEPTH) begin
            rxb[rx_cnt_r[RXB_AW-1:0]] <= i_rx_byte;
        end
        if (i_db_wr) begin
            db_mem[{i_db_page, i_db_loc}] <= i_db_data;
        end else if (host_we) begin
            db_mem[{page_r, wr_loc[LOC_AW-1:0]}] <= wr_val;
        end
    end

    always @(posedge i_clk_sys) begin
        if (i_reset) begin
            state_r <= S_IDLE;
            rx_cnt_r <= 9'h000;
            rx_ovf_r <= 1'b0;
            rx_crc_r <= `MDBS_CRC_INIT;
            page_r <= 2'h0;
            exc_r <= `MDBS_EXC_NONE;
            len_r <= 9'h000;
            tx_idx_r <= 9'h000;
            tx_crc_r <= `MDBS_CRC_INIT;
            wr_cnt_r <= 8'h00;
            cmd_pend_r <= 1'b0;
            o_busy <= 1'b0;
            o_tx_valid <= 1'b0;
            o_tx_byte <= 8'h00;
            o_tx_last <= 1'b0;
            o_cmd_valid <= 1'b0;
            o_cmd_page <= 2'h0;
            o_cmd_loc <= 16'h0000;
            o_cmd_data <= 16'h0000;
            o_alarm_accept <= 1'b0;
        end else begin
            o_alarm_accept <= 1'b0;
            if (o_cmd_valid && i_cmd_ready) begin
                o_cmd_valid <= 1'b0;
            end
            case (state_r)
                S_IDLE: begin
                    // a held command leaves only once the reply has gone out
                    if (cmd_pend_r && !o_cmd_valid) begin
                        o_cmd_valid <= 1'b1;
                        cmd_pend_r <= 1'b0;
                    end
                    if (i_rx_valid) begin
                        rx_crc_r <= rx_crc_nxt;
                        if (rx_cnt_r < RXB_DEPTH) begin
                            rx_cnt_r <= rx_cnt_r + 9'h001;
                        end else begin
                            rx_ovf_r <= 1'b1;
                        end
                        if (i_rx_end) begin
                            state_r <= S_CHECK;
                            o_busy <= 1'b1;
                        end
                    end
                end
                S_CHECK: begin
                    rx_cnt_r <= 9'h000;
                    rx_ovf_r <= 1'b0;
                    rx_crc_r <= `MDBS_CRC_INIT;
                    page_r <= chk_page;
                    exc_r <= chk_exc;
                    len_r <= chk_len;
                    wr_cnt_r <= 8'h00;
                    tx_idx_r <= 9'h000;
                    tx_crc_r <= `MDBS_CRC_INIT;
                    if (!crc_ok || !chk_match) begin
                        state_r <= S_IDLE;
                        o_busy <= 1'b0;
                    end else if (chk_exc == `MDBS_EXC_NONE && fc_wr) begin
                        state_r <= S_WRITE;
                    end else if (!chk_bcast) begin
                        state_r <= S_TX;
                    end else begin
                        state_r <= S_IDLE;
                        o_busy <= 1'b0;
                    end
                end
                S_WRITE: begin
                    if (host_we) begin
                        if (page_r == 2'h0 && wr_loc == `MDBS_LOC_ALARM_ACCEPT && wr_val != 16'h0000) begin
                            o_alarm_accept <= 1'b1;
                        end
                        if (is_unit(page_r, wr_loc)) begin
                            cmd_pend_r <= 1'b1;
                            o_cmd_page <= page_r;
                            o_cmd_loc <= wr_loc;
                            if (wr_loc >= `MDBS_LOC_POS_FIRST && wr_loc <= `MDBS_LOC_POS_LAST) begin
                                o_cmd_data <= scale(wr_val);
                            end else begin
                                o_cmd_data <= wr_val;
                            end
                        end
                        wr_cnt_r <= wr_cnt_r + 8'h01;
                        if (wr_last) begin
                            if (f_addr == `MDBS_ADDR_BCAST) begin
                                state_r <= S_IDLE;
                                o_busy <= 1'b0;
                            end else begin
                                state_r <= S_TX;
                            end
                        end
                    end
                end
                S_TX: begin
                    if (!o_tx_valid || i_tx_ready) begin
                        if (tx_idx_r <= len_r + 9'h001) begin
                            o_tx_valid <= 1'b1;
                            o_tx_byte <= gen_byte;
                            o_tx_last <= (tx_idx_r == len_r + 9'h001);
                            tx_idx_r <= tx_idx_r + 9'h001;
                            if (tx_idx_r < len_r) begin
                                tx_crc_r <= tx_crc_nxt;
                            end
                        end else begin
                            o_tx_valid <= 1'b0;
                            o_tx_last <= 1'b0;
                            state_r <= S_IDLE;
                            o_busy <= 1'b0;
                        end
                    end
                end
                default: begin
                    state_r <= S_IDLE;
                    o_busy <= 1'b0;
                end
            endcase
        end
    end
endmodule // mdbs_slave
`default_nettype wire

// ==== mdbs_defines.vh ====
// constants for the database slave: function codes, locations, limits, frame layout
// How it works
// - frame is unit address, function code, location, quantity, optional data, CRC.
// - address 0 is broadcast; only addresses 1 to 247 may be configured.
// - packed layout answers one unit address holding own and all unit data.
// - generic layout: units 61-120 at base plus one, 121-180 at base plus two.
// - locations count from zero; frame location equals database location unchanged.
// - status word at register 0 by code 03, discretes 0-15 by code 01.
// - nonzero write to location 5 accepts alarm; zero does nothing, no cancel needed.
// - write or read is decided by function code alone, never by location.
// - codes 05 and 06 carry a register location, decoded as a register.
// - unit status readable as registers by 04, as 16 discretes by 02.
// - one code 04 request for 60 registers returns 60 units of status.
// - analogue half scale is 0x3fff in 15-bit form, 0x07ff in 12-bit form.
// - packed variants share locations; analogue two's complement versus plain integer.
// - each port picks its own layout; network ports share one database.
// - slave only; reads are served from the local database without polling units.
// - exceptions: 01 function or length, 02 location, 03 value, 06 busy.
// - unit write: reply goes to the host first, then the command is forwarded.
`ifndef MDBS_DEFINES_VH
`define MDBS_DEFINES_VH
`define MDBS_ADDR_BCAST 8'h00
`define MDBS_ADDR_MAX 8'hf7
`define MDBS_GEN_PAGES 8'h02
`define MDBS_FC_RD_COILS 8'h01
`define MDBS_FC_RD_INPUTS 8'h02
`define MDBS_FC_RD_HOLD 8'h03
`define MDBS_FC_RD_INREG 8'h04
`define MDBS_FC_WR_COIL 8'h05
`define MDBS_FC_WR_REG 8'h06
`define MDBS_FC_WR_COILS 8'h0f
`define MDBS_FC_WR_REGS 8'h10
`define MDBS_FC_EXC_FLAG 8'h80
`define MDBS_EXC_NONE 8'h00
`define MDBS_EXC_FUNC 8'h01
`define MDBS_EXC_ADDR 8'h02
`define MDBS_EXC_VALUE 8'h03
`define MDBS_EXC_BUSY 8'h06
`define MDBS_LOC_STATUS 16'h0000
`define MDBS_LOC_ALARM_ACCEPT 16'h0005
`define MDBS_LOC_UNIT_STATUS 16'h04c0
`define MDBS_LOC_POS_UNIT26 16'h0ab5
`define MDBS_LOC_OPEN_RELAY4 16'h0c7f
`define MDBS_LOC_POS_FIRST 16'h0a9c
`define MDBS_LOC_POS_LAST 16'h0ad7
`define MDBS_MAX_BITS 16'h07d0
`define MDBS_MAX_REGS 16'h007d
`define MDBS_MAX_WR_COILS 16'h0010
`define MDBS_LEN_FIXED 9'h008
`define MDBS_LEN_MULTI 9'h009
`define MDBS_LEN_MIN 9'h004
`define MDBS_CRC_INIT 16'hffff
`define MDBS_CRC_POLY 16'ha001
`endif

// ==== mdbs_crc16.v ====
// one byte step of the reflected 16-bit frame check
`timescale 1ns/1ps
`default_nettype none
`include "mdbs_defines.vh"
module mdbs_crc16 (
    input wire [15:0] i_crc,
    input wire [7:0] i_byte,
    output reg [15:0] o_crc
);
    integer b;
    always @* begin
        o_crc = i_crc ^ {8'h00, i_byte};
        for (b = 0; b < 8; b = b + 1) begin
            if (o_crc[0]) begin
                o_crc = (o_crc >> 1) ^ `MDBS_CRC_POLY;
            end else begin
                o_crc = o_crc >> 1;
            end
        end
    end
endmodule // mdbs_crc16
`default_nettype wire

// ==== mdbs_slave_asserts.sv ====
// concurrent checks on the ports of the gateway slave
`timescale 1ns/1ps
`default_nettype none
module mdbs_slave_chk (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic [7:0] i_base_addr,
    input wire logic i_layout_packed,
    input wire logic i_rx_valid,
    input wire logic i_rx_end,
    input wire logic o_busy,
    input wire logic o_tx_valid,
    input wire logic [7:0] o_tx_byte,
    input wire logic o_tx_last,
    input wire logic i_tx_ready,
    input wire logic o_cmd_valid,
    input wire logic [1:0] o_cmd_page,
    input wire logic [15:0] o_cmd_loc,
    input wire logic [15:0] o_cmd_data,
    input wire logic i_cmd_ready,
    input wire logic o_alarm_accept
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    a_reset_quiet: assert property ($fell(i_reset) |-> !o_busy && !o_tx_valid && !o_cmd_valid)
        else $error("outputs active after reset");
    a_tx_hold: assert property (
        o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_byte) && $stable(o_tx_last))
        else $error("stalled byte changed");
    a_tx_in_busy: assert property (o_tx_valid |-> o_busy)
        else $error("reply while idle");
    a_end_check: assert property (
        i_rx_valid && i_rx_end && !o_busy |=> o_busy && !o_tx_valid)
        else $error("no busy after frame end");
    a_last_ends: assert property (
        o_tx_valid && o_tx_last && i_tx_ready |=> !o_tx_valid)
        else $error("reply past last byte");
    a_first_addr: assert property ($rose(o_tx_valid) |->
        (o_tx_byte == i_base_addr || (!i_layout_packed &&
        (o_tx_byte == i_base_addr + 8'h01 || o_tx_byte == i_base_addr + 8'h02))))
        else $error("reply from wrong address");
    a_cmd_hold: assert property (o_cmd_valid && !i_cmd_ready |=>
        o_cmd_valid && $stable(o_cmd_page) && $stable(o_cmd_loc) && $stable(o_cmd_data))
        else $error("command not held");
    a_cmd_after: assert property ($rose(o_cmd_valid) |-> !o_tx_valid)
        else $error("command during reply");
    a_alarm_pulse: assert property (o_alarm_accept |=> !o_alarm_accept)
        else $error("alarm pulse too long");
endmodule // mdbs_slave_chk
bind mdbs_slave mdbs_slave_chk i_chk (.*);
`default_nettype wire

// ==== mdbs_host_model.sv ====
// host model: sends requests, takes replies under back-pressure
`timescale 1ns/1ps
`default_nettype none
module mdbs_host_model (
    input wire logic i_clk_sys,
    output logic o_req_valid = 1'b0,
    output logic [7:0] o_req_byte = 8'h00,
    output logic o_req_end = 1'b0,
    output logic o_rsp_ready,
    input wire logic i_rsp_valid,
    input wire logic [7:0] i_rsp_byte,
    input wire logic i_rsp_last
);
    logic [7:0] got[$];
    int n_last = 0;
    logic [1:0] stall_r = 2'h0;
    // one stall in four so the reply must hold its byte
    always @(negedge i_clk_sys) begin
        stall_r <= stall_r + 2'h1;
        o_rsp_ready <= (stall_r != 2'h3);
    end
    always @(posedge i_clk_sys) begin
        if (i_rsp_valid && o_rsp_ready) begin
            got.push_back(i_rsp_byte);
            if (i_rsp_last)
                n_last <= n_last + 1;
        end
    end
    // idle data shows the inverse of the last byte
    task send(input logic [7:0] fr[$]);
        for (int k = 0; k < fr.size(); k++) begin
            @(negedge i_clk_sys);
            o_req_valid = 1'b1;
            o_req_byte = fr[k];
            o_req_end = (k == fr.size() - 1);
        end
        @(negedge i_clk_sys);
        o_req_valid = 1'b0;
        o_req_end = 1'b0;
        o_req_byte = ~o_req_byte;
    endtask
endmodule // mdbs_host_model
`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench for the gateway slave port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic i_clk_sys, i_reset = 1'b1, i_layout_packed = 1'b0, i_scale_alt = 1'b0;
    logic i_db_wr = 1'b0, i_cmd_ready = 1'b0;
    logic [7:0] i_base_addr = 8'h01;
    logic [15:0] i_station_status, i_db_data;
    logic [1:0] i_db_page;
    logic [11:0] i_db_loc;
    wire logic i_rx_valid, i_rx_end, i_tx_ready, o_busy, o_tx_valid, o_tx_last;
    wire logic o_cmd_valid, o_alarm_accept;
    wire logic [7:0] i_rx_byte, o_tx_byte;
    wire logic [1:0] o_cmd_page;
    wire logic [15:0] o_cmd_loc, o_cmd_data;
    int err_count = 0, n_tests = 0, alarm_cnt = 0, tn = 0;
    logic [31:0] lfsr_r = 32'hd423d81a;
    logic [15:0] mdb[int];
    logic [7:0] none[$];
    logic [15:0] v;
    mdbs_slave #(.LOC_AW(12), .RXB_AW(6)) i_dut (.*);
    mdbs_host_model i_host (.i_clk_sys, .o_req_valid(i_rx_valid), .o_req_byte(i_rx_byte),
        .o_req_end(i_rx_end), .o_rsp_ready(i_tx_ready), .i_rsp_valid(o_tx_valid),
        .i_rsp_byte(o_tx_byte), .i_rsp_last(o_tx_last));
    initial begin
        i_clk_sys = 1'b0;
        forever #2.5 i_clk_sys = ~i_clk_sys;
    end
    always @(posedge i_clk_sys) if (o_alarm_accept === 1'b1) alarm_cnt <= alarm_cnt + 1;
    function logic [15:0] rnd();
        lfsr_r = {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
        return lfsr_r[15:0];
    endfunction
    function automatic logic [15:0] crc(input logic [7:0] f[$]);
        logic [15:0] c = 16'hffff;
        foreach (f[k]) begin
            c = c ^ {8'h00, f[k]};
            repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
        end
        return c;
    endfunction
    // page 0 location 0 is the live status word
    function logic [15:0] mword(input int pg, input int loc);
        return (pg == 0 && loc == 0) ? i_station_status : mdb[pg * 4096 + loc];
    endfunction
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task done();
        tn++;
        $display("test %0d done", tn);
    endtask
    task dbw(input int pg, input int loc);
        @(negedge i_clk_sys);
        i_db_wr = 1'b1;
        i_db_page = 2'(pg);
        i_db_loc = 12'(loc);
        i_db_data = rnd();
        mdb[pg * 4096 + loc] = i_db_data;
        @(negedge i_clk_sys);
        i_db_wr = 1'b0;
    endtask
    task xact(input logic [7:0] rq[$], input logic [7:0] ex[$], input logic bad);
        logic [15:0] c;
        int n0;
        c = crc(rq);
        rq.push_back(c[7:0] ^ {7'h00, bad});
        rq.push_back(c[15:8]);
        if (ex.size() > 0) begin
            c = crc(ex);
            ex.push_back(c[7:0]);
            ex.push_back(c[15:8]);
        end
        i_host.got.delete();
        n0 = i_host.n_last;
        i_host.send(rq);
        for (int t = 0; t < 3000 && ex.size() > 0 && i_host.n_last == n0; t++)
            @(negedge i_clk_sys);
        repeat (4) @(negedge i_clk_sys);
        for (int t = 0; t < 50 && o_busy !== 1'b0; t++) @(negedge i_clk_sys);
        chk({15'h0000, o_busy}, 16'h0000);
        chk(16'(i_host.got.size()), 16'(ex.size()));
        for (int k = 0; k < ex.size() && k < i_host.got.size(); k++)
            chk({8'h00, i_host.got[k]}, {8'h00, ex[k]});
    endtask
    task rd(input logic [7:0] a, f, input logic [15:0] loc, qty, input int pg);
        logic [7:0] ex[$];
        logic [7:0] b;
        logic [15:0] w;
        int d;
        ex = {a, f, (f < 8'h03) ? 8'((qty + 7) / 8) : 8'(2 * qty)};
        for (int k = 0; f < 8'h03 && k < (qty + 7) / 8; k++) begin
            b = 8'h00;
            for (int j = 0; j < 8 && k * 8 + j < qty; j++) begin
                d = loc + k * 8 + j;
                w = mword(pg, d >> 4);
                b[j] = w[d % 16];
            end
            ex.push_back(b);
        end
        for (int k = 0; f > 8'h02 && k < qty; k++) begin
            w = mword(pg, loc + k);
            ex.push_back(w[15:8]);
            ex.push_back(w[7:0]);
        end
        xact({a, f, loc[15:8], loc[7:0], qty[15:8], qty[7:0]}, ex, 1'b0);
    endtask
    task wr(input logic [7:0] rq[$]);
        xact(rq, rq[0:5], 1'b0);
    endtask
    task exc(input logic [7:0] rq[$], input logic [7:0] code);
        xact(rq, {rq[0], rq[1] | 8'h80, code}, 1'b0);
    endtask
    task wa(input logic [7:0] rq[$], input int n);
        int a0;
        a0 = alarm_cnt;
        if (rq[0] == 8'h00)
            xact(rq, none, 1'b0);
        else
            wr(rq);
        chk(16'(alarm_cnt - a0), 16'(n));
    endtask
    // checks a held command, optionally refusing a second unit write as busy
    task cmd(input logic [15:0] loc, d, input logic busy_try);
        for (int t = 0; t < 8 && o_cmd_valid !== 1'b1; t++) @(negedge i_clk_sys);
        chk({14'h0000, o_cmd_page}, 16'h0000);
        chk(o_cmd_loc, loc);
        chk(o_cmd_data, d);
        if (busy_try)
            exc({8'h01, 8'h06, 8'h0c, 8'h7f, 8'h00, 8'h00}, 8'h06);
        i_cmd_ready = 1'b1;
        @(negedge i_clk_sys);
        i_cmd_ready = 1'b0;
        @(negedge i_clk_sys);
        chk({15'h0000, o_cmd_valid}, 16'h0000);
    endtask
    initial begin
        #100000;
        err_count++;
        $display("watchdog expired");
        end_sim();
    end
    initial begin
        i_station_status = rnd();
        repeat (3) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        i_reset = 1'b0;
        rd(8'h01, 8'h03, 16'h0000, 16'h0001, 0);
        rd(8'h01, 8'h01, 16'h0000, 16'h0010, 0);
        done();
        for (int k = 0; k < 60; k++) for (int p = 0; p < 3; p++) dbw(p, 12'h4c0 + k);
        rd(8'h01, 8'h04, 16'h04cb, 16'h0001, 0);
        rd(8'h01, 8'h02, 16'h4cb0, 16'h0010, 0);
        rd(8'h01, 8'h02, 16'h4c03, 16'h0013, 0);
        rd(8'h02, 8'h04, 16'h04c1, 16'h0001, 1);
        rd(8'h03, 8'h04, 16'h04c0, 16'h003c, 2);
        done();
        wa({8'h01, 8'h05, 8'h00, 8'h05, 8'hff, 8'h00}, 1);
        wa({8'h01, 8'h06, 8'h00, 8'h05, 8'h00, 8'h00}, 0);
        wa({8'h01, 8'h10, 8'h00, 8'h05, 8'h00, 8'h01, 8'h02, 8'hff, 8'h00}, 1);
        wa({8'h01, 8'h0f, 8'h00, 8'h05, 8'h00, 8'h01, 8'h01, 8'h01}, 1);
        wa({8'h00, 8'h05, 8'h00, 8'h05, 8'hff, 8'h00}, 1);
        done();
        wr({8'h01, 8'h06, 8'h0c, 8'h7f, 8'hff, 8'h00});
        cmd(16'h0c7f, 16'hff00, 1'b1);
        wr({8'h01, 8'h05, 8'h0c, 8'h7f, 8'hff, 8'h00});
        cmd(16'h0c7f, 16'hff00, 1'b0);
        for (int s = 0; s < 2; s++) begin
            i_scale_alt = s[0];
            v = s[0] ? 16'h07ff : 16'h3fff;
            wr({8'h01, 8'h06, 8'h0a, 8'hb5, v[15:8], v[7:0]});
            cmd(16'h0ab5, s[0] ? v << 4 : v << 1, 1'b0);
        end
        done();
        exc({8'h01, 8'h08, 8'h00, 8'h00, 8'h12, 8'h34}, 8'h01);
        exc({8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00}, 8'h03);
        exc({8'h01, 8'h03, 8'h0f, 8'hff, 8'h00, 8'h02}, 8'h02);
        done();
        xact({8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, none, 1'b1);
        xact({8'h05, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, none, 1'b0);
        xact({8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, none, 1'b0);
        i_layout_packed = 1'b1;
        xact({8'h02, 8'h04, 8'h04, 8'hc1, 8'h00, 8'h01}, none, 1'b0);
        rd(8'h01, 8'h04, 16'h04c1, 16'h0001, 0);
        done();
        end_sim();
    end
endmodule // tb_top
`default_nettype wire
